// ### rtl/boot_seq_pkg.sv
// constants and types shared by the start-up sequencer files
package boot_seq_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int XTAL_SETTLE_US = 1000;
    localparam int XTAL_SETTLE_CYCLES = XTAL_SETTLE_US * (CLK_FREQ_HZ / 1_000_000);

    // ****************************************
    // address map of the boot fetch path
    // ****************************************
    localparam logic [31:0] RESET_VECTOR = 32'ha000_0000;
    localparam logic [2:0] DIRECT_SEG_TOP = 3'h5;
    localparam logic [31:0] DIRECT_SEG_SPAN_MASK = 32'h1fff_ffff;
    localparam logic [31:0] SRAM0_BASE = 32'h0000_0000;
    localparam logic [31:0] SRAM0_MASK = 32'hfc00_0000;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] PLL_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CLK_DIV_OFFSET = 8'h04;
    localparam logic [7:0] CLK_GATE_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0c;
    localparam logic [1:0] PLL_CTRL_RESET = 2'h0;
    localparam logic [31:0] CLK_DIV_RESET = 32'h0000_0000;
    localparam logic [7:0] CLK_GATE_RESET = 8'hff;
    localparam int STATUS_RELEASED_BIT = 0;
    localparam int STATUS_CRYSTAL_BIT = 1;
    localparam int STATUS_STATE_LSB = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        ST_SUPPLY = 2'b00,
        ST_SETTLE = 2'b01,
        ST_RUN = 2'b10
    } seq_state_e;

endpackage

// ### rtl/level_sync.sv
// two-stage synchroniser for pin levels
`timescale 1ns/1ns
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] pin_level,
    output logic [WIDTH-1:0] sync_level
);

    initial begin
        if (WIDTH < 1) begin
            $error("level_sync: WIDTH must be at least 1");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } sync_s;

    sync_s s_reg;
    sync_s s_next;

    // first stage feeds the second stage only
    always_comb begin
        s_next.meta = pin_level;
        s_next.held = s_reg.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_level = s_reg.held;

endmodule // level_sync

// ### rtl/fetch_addr_decode.sv
// virtual to physical mapping and chip select decode for instruction fetch
`timescale 1ns/1ns
module fetch_addr_decode (
    input wire logic [31:0] vaddr,
    output logic [31:0] paddr,
    output logic uncached_direct_segment,
    output logic external_sram_select_zero
);

    always_comb begin
        // direct segment: no translation, no cache, fixed onto the low 512 MB
        if (vaddr[31:29] == boot_seq_pkg::DIRECT_SEG_TOP) begin // RULE8
            uncached_direct_segment = 1'b1;
            paddr = vaddr & boot_seq_pkg::DIRECT_SEG_SPAN_MASK; // RULE8
        end else begin
            // other segments: vaddr is passed on unchanged as paddr, with no mmu translation
            uncached_direct_segment = 1'b0;
            paddr = vaddr;
        end
        external_sram_select_zero =
            (paddr & boot_seq_pkg::SRAM0_MASK) == boot_seq_pkg::SRAM0_BASE; // RULE9
    end

endmodule // fetch_addr_decode

// ### rtl/boot_reset_clock_sequencer.sv
// start-up reset and clock sequencer with boot fetch decode and axi4-lite registers
//
// Function
// RULE1: hold all logic in reset while the supply-rise detector says the supply is not up.
// RULE2: after the supply-rise reset, run from the primary clock pin as the only clock.
// RULE3: read the oscillator select strap to learn whether a crystal or a clock is fitted.
// RULE4: with a crystal, extend reset until the oscillator has settled.
// RULE5: with an external clock, release reset without any settling delay.
// RULE6: at start-up all plls are off and every module clock runs undivided.
// RULE7: after release the processor fetches first from the fixed reset address.
// RULE8: the uncached direct segment bypasses mmu and cache and maps onto the low 512 MB.
// RULE9: physical address zero selects external sram chip select zero.
// RULE10: boot code may later enable plls, set dividers and gate unused clocks.
// RULE11: internal reset is released synchronously so all flops leave reset on one edge.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module boot_reset_clock_sequencer #(
    parameter int SETTLE_CYCLES = boot_seq_pkg::XTAL_SETTLE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic supply_risen,
    input wire logic oscillator_select_strap,
    output logic core_reset_n,
    output logic core_start,
    output logic [31:0] boot_vector,
    output logic [1:0] pll_enable,
    output logic [31:0] clock_divider,
    output logic [7:0] module_clock_enable,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_vaddr,
    output logic fetch_valid,
    output logic [31:0] fetch_paddr,
    output logic fetch_uncached,
    output logic external_sram_select_zero,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    initial begin
        if (SETTLE_CYCLES < 1) begin
            $error("boot_reset_clock_sequencer: SETTLE_CYCLES must be at least 1");
        end
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        boot_seq_pkg::seq_state_e st;
        logic [31:0] settle_cnt;
        logic crystal;
        logic core_reset_n;
        logic core_start;
        logic [1:0] pll_en;
        logic [31:0] div;
        logic [7:0] gate;
        logic fetch_valid;
        logic [31:0] fetch_paddr;
        logic fetch_uncached;
        logic sram0;
        logic aw_held;
        logic [7:0] aw_addr;
        logic aw_bad;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } seq_s;

    seq_s s_reg;
    seq_s s_next;

    logic supply_ok;
    logic strap_level;
    logic [31:0] dec_paddr;
    logic dec_uncached;
    logic dec_sram0;

    // ****************************************
    // pin synchronisers and fetch decode
    // ****************************************
    level_sync #(
        .WIDTH(2)
    ) pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_level({supply_risen, oscillator_select_strap}),
        .sync_level({supply_ok, strap_level})
    );

    fetch_addr_decode fetch_dec (
        .vaddr(fetch_vaddr),
        .paddr(dec_paddr),
        .uncached_direct_segment(dec_uncached),
        .external_sram_select_zero(dec_sram0)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0] strb);
        logic [31:0] merged;
        merged = old_word;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merged[b*8 +: 8] = new_word[b*8 +: 8];
            end
        end
        return merged;
    endfunction

    function automatic logic is_mapped(input logic [31:0] addr);
        return addr[31:8] == 24'h00_0000 && addr[1:0] == 2'h0 &&
            (addr[7:0] == boot_seq_pkg::PLL_CTRL_OFFSET ||
             addr[7:0] == boot_seq_pkg::CLK_DIV_OFFSET ||
             addr[7:0] == boot_seq_pkg::CLK_GATE_OFFSET ||
             addr[7:0] == boot_seq_pkg::STATUS_OFFSET);
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [31:0] status_word;
        status_word = '0;
        s_next = s_reg;
        s_next.core_start = 1'b0;

        // reset sequencing
        case (s_reg.st)
            boot_seq_pkg::ST_SUPPLY: begin
                s_next.core_reset_n = 1'b0; // RULE1
                if (supply_ok) begin // RULE2
                    // strap caught each time the supply comes up; low means crystal
                    s_next.crystal = ~strap_level; // RULE3
                    s_next.settle_cnt = '0;
                    if (!strap_level) begin
                        s_next.st = boot_seq_pkg::ST_SETTLE; // RULE4
                    end else begin
                        s_next.st = boot_seq_pkg::ST_RUN; // RULE5
                        s_next.core_reset_n = 1'b1; // RULE11
                        s_next.core_start = 1'b1;
                    end
                end
            end
            boot_seq_pkg::ST_SETTLE: begin
                s_next.settle_cnt = s_reg.settle_cnt + 32'h0000_0001;
                if (!supply_ok) begin
                    s_next.st = boot_seq_pkg::ST_SUPPLY; // RULE1
                end else if (s_reg.settle_cnt == 32'(SETTLE_CYCLES - 1)) begin // RULE4
                    s_next.st = boot_seq_pkg::ST_RUN;
                    s_next.core_reset_n = 1'b1; // RULE11
                    s_next.core_start = 1'b1;
                end
            end
            boot_seq_pkg::ST_RUN: begin
                if (!supply_ok) begin
                    s_next.st = boot_seq_pkg::ST_SUPPLY; // RULE1
                    s_next.core_reset_n = 1'b0;
                end
            end
            default: begin
                s_next.st = boot_seq_pkg::ST_SUPPLY;
                s_next.core_reset_n = 1'b0;
            end
        endcase

        // clock controls fall back to the start-up set whenever the core is in reset
        if (!s_next.core_reset_n) begin
            s_next.pll_en = boot_seq_pkg::PLL_CTRL_RESET; // RULE6
            s_next.div = boot_seq_pkg::CLK_DIV_RESET; // RULE6
            s_next.gate = boot_seq_pkg::CLK_GATE_RESET; // RULE6
        end

        // fetch path: decoded one cycle after the request, blocked while in reset
        s_next.fetch_valid = fetch_req && s_reg.core_reset_n;
        if (fetch_req && s_reg.core_reset_n) begin
            s_next.fetch_paddr = dec_paddr; // RULE8
            s_next.fetch_uncached = dec_uncached;
            s_next.sram0 = dec_sram0; // RULE9
        end

        // axi write address and data, taken in either order
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr[7:0];
            s_next.aw_bad = !is_mapped(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_held = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = s_reg.aw_bad ? boot_seq_pkg::RESP_DECERR : boot_seq_pkg::RESP_OKAY;
            // writes while the core is held in reset are acknowledged but dropped
            if (!s_reg.aw_bad && s_reg.core_reset_n && s_next.core_reset_n) begin
                case (s_reg.aw_addr)
                    boot_seq_pkg::PLL_CTRL_OFFSET: begin
                        s_next.pll_en = 2'(merge_bytes(32'(s_reg.pll_en), s_reg.wdata,
                                                       s_reg.wstrb)); // RULE10
                    end
                    boot_seq_pkg::CLK_DIV_OFFSET: begin
                        s_next.div = merge_bytes(s_reg.div, s_reg.wdata, s_reg.wstrb); // RULE10
                    end
                    boot_seq_pkg::CLK_GATE_OFFSET: begin
                        s_next.gate = 8'(merge_bytes(32'(s_reg.gate), s_reg.wdata,
                                                     s_reg.wstrb)); // RULE10
                    end
                    default: begin
                        s_next.gate = s_next.gate;
                    end
                endcase
            end
        end

        // axi read
        status_word[boot_seq_pkg::STATUS_RELEASED_BIT] = s_reg.core_reset_n;
        status_word[boot_seq_pkg::STATUS_CRYSTAL_BIT] = s_reg.crystal;
        status_word[boot_seq_pkg::STATUS_STATE_LSB +: 2] = s_reg.st;
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = boot_seq_pkg::RESP_OKAY;
            case (s_axi_araddr[7:0])
                boot_seq_pkg::PLL_CTRL_OFFSET: s_next.rdata = 32'(s_reg.pll_en);
                boot_seq_pkg::CLK_DIV_OFFSET: s_next.rdata = s_reg.div;
                boot_seq_pkg::CLK_GATE_OFFSET: s_next.rdata = 32'(s_reg.gate);
                boot_seq_pkg::STATUS_OFFSET: s_next.rdata = status_word;
                default: s_next.rdata = '0;
            endcase
            if (!is_mapped(s_axi_araddr)) begin
                s_next.rdata = '0;
                s_next.rresp = boot_seq_pkg::RESP_DECERR;
            end
        end

        // ready lines are registered: one transfer per channel in flight
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready = !s_next.w_held && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.st <= boot_seq_pkg::ST_SUPPLY;
            s_reg.core_reset_n <= 1'b0; // RULE1
            s_reg.pll_en <= boot_seq_pkg::PLL_CTRL_RESET; // RULE6
            s_reg.div <= boot_seq_pkg::CLK_DIV_RESET;
            s_reg.gate <= boot_seq_pkg::CLK_GATE_RESET;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign core_reset_n = s_reg.core_reset_n;
    assign core_start = s_reg.core_start;
    assign boot_vector = boot_seq_pkg::RESET_VECTOR; // RULE7
    assign pll_enable = s_reg.pll_en;
    assign clock_divider = s_reg.div;
    assign module_clock_enable = s_reg.gate;
    assign fetch_valid = s_reg.fetch_valid;
    assign fetch_paddr = s_reg.fetch_paddr;
    assign fetch_uncached = s_reg.fetch_uncached;
    assign external_sram_select_zero = s_reg.sram0;
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;

endmodule // boot_reset_clock_sequencer

// ### verification/boot_sram_model.sv
// boot sram model answering instruction fetches on select zero
`timescale 1ns/1ns
module boot_sram_model (
    input wire logic aclk,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_paddr,
    input wire logic external_sram_select_zero,
    output logic [31:0] read_word
);
    logic [31:0] mem [0:15];
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 32'h5a00_0000 + i;
        end
        read_word = 32'h0;
    end
    always @(posedge aclk) begin
        if (fetch_valid && external_sram_select_zero) begin
            read_word <= mem[fetch_paddr[5:2]];
        end else begin
            // released bus inverts the last word every cycle, so it shows the stale word again every second cycle
            read_word <= ~read_word;
        end
    end
endmodule // boot_sram_model

// ### verification/boot_seq_chk.sv
// concurrent checks on the start-up sequencer ports
`timescale 1ns/1ns
module boot_seq_chk #(
    parameter int SETTLE_CYCLES = boot_seq_pkg::XTAL_SETTLE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic supply_risen,
    input wire logic oscillator_select_strap,
    input wire logic core_reset_n,
    input wire logic core_start,
    input wire logic [31:0] boot_vector,
    input wire logic [1:0] pll_enable,
    input wire logic [31:0] clock_divider,
    input wire logic [7:0] module_clock_enable,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_vaddr,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_paddr,
    input wire logic fetch_uncached,
    input wire logic external_sram_select_zero,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    // ****************************************
    // helpers and properties
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] wait_cnt;
    logic [31:0] vaddr_q;
    // counts supply-up cycles spent still in reset
    always_ff @(posedge aclk) begin
        if (!aresetn || !supply_risen || core_reset_n) begin
            wait_cnt <= 16'h0;
        end else begin
            wait_cnt <= wait_cnt + 16'h1;
        end
        vaddr_q <= fetch_vaddr;
    end
    a_supply_hold: assert property (!supply_risen [*3] |=> !core_reset_n)
        else $error("core left running with supply down");
    a_start_edge: assert property (core_start == $rose(core_reset_n))
        else $error("start pulse not on release edge");
    a_vector_fixed: assert property (boot_vector == 32'ha000_0000)
        else $error("boot vector wrong");
    a_startup_clocks: assert property ($rose(core_reset_n) |-> pll_enable == 2'h0
        && clock_divider == 32'h0 && module_clock_enable == 8'hff)
        else $error("clock controls not at start-up set");
    a_settle_time: assert property ($rose(core_reset_n) |-> (oscillator_select_strap
        ? wait_cnt <= 16'h4 : wait_cnt >= SETTLE_CYCLES))
        else $error("release delay wrong for strap");
    a_fetch_answer: assert property (fetch_req && core_reset_n |=> fetch_valid)
        else $error("fetch not answered");
    a_segment_map: assert property (fetch_valid |-> fetch_uncached ==
        (vaddr_q[31:29] == 3'b101) && fetch_paddr ==
        (fetch_uncached ? (vaddr_q & 32'h1fff_ffff) : vaddr_q))
        else $error("segment mapping wrong");
    a_sram_decode: assert property (fetch_valid |->
        external_sram_select_zero == (fetch_paddr[31:26] == 6'h0))
        else $error("select zero decode wrong");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held too long");
    c_ext_release: cover property ($rose(core_reset_n) && oscillator_select_strap);
    c_xtal_release: cover property ($rose(core_reset_n) && !oscillator_select_strap);
    c_sram_fetch: cover property (fetch_valid && external_sram_select_zero);
endmodule // boot_seq_chk

bind boot_reset_clock_sequencer boot_seq_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (
    .aclk(aclk), .aresetn(aresetn), .supply_risen(supply_risen),
    .oscillator_select_strap(oscillator_select_strap), .core_reset_n(core_reset_n),
    .core_start(core_start), .boot_vector(boot_vector), .pll_enable(pll_enable),
    .clock_divider(clock_divider), .module_clock_enable(module_clock_enable),
    .fetch_req(fetch_req), .fetch_vaddr(fetch_vaddr), .fetch_valid(fetch_valid),
    .fetch_paddr(fetch_paddr), .fetch_uncached(fetch_uncached),
    .external_sram_select_zero(external_sram_select_zero), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// ### verification/boot_reset_clock_sequencer_test.sv
// self-checking bench for the start-up sequencer
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    samples_checked++; \
    if ((got) !== (ex)) begin \
        miscompares++; \
        $display("CHECK FAILED %s exp %h seen %h", nm, ex, got); \
    end
module boot_reset_clock_sequencer_test;
    // ****************************************
    // signals and design
    // ****************************************
    localparam int SETTLE = 8;
    logic aclk = 1'b0, aresetn = 1'b0, supply_risen = 1'b0, strap = 1'b1, fetch_req = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] fetch_vaddr = 32'h0, awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic core_reset_n, core_start, fetch_valid, fetch_uncached, sel, due = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] pll_enable, bresp, rresp, eb;
    logic [31:0] boot_vector, clock_divider, fetch_paddr, rdata, read_word, wexp;
    logic [7:0] module_clock_enable;
    logic [33:0] fq[$], rq[$], e;
    logic [1:0] bq[$];
    int miscompares = 0, samples_checked = 0;
    always #10 aclk = ~aclk;
    boot_reset_clock_sequencer #(.SETTLE_CYCLES(SETTLE)) DUT (
        .aclk(aclk), .aresetn(aresetn), .supply_risen(supply_risen),
        .oscillator_select_strap(strap), .core_reset_n(core_reset_n), .core_start(core_start),
        .boot_vector(boot_vector), .pll_enable(pll_enable), .clock_divider(clock_divider),
        .module_clock_enable(module_clock_enable), .fetch_req(fetch_req),
        .fetch_vaddr(fetch_vaddr), .fetch_valid(fetch_valid), .fetch_paddr(fetch_paddr),
        .fetch_uncached(fetch_uncached), .external_sram_select_zero(sel),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    boot_sram_model MODEL (.aclk(aclk), .fetch_valid(fetch_valid), .fetch_paddr(fetch_paddr),
        .external_sram_select_zero(sel), .read_word(read_word));
    // ****************************************
    // tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            miscompares++;
            $display("CHECK FAILED wait exp done seen timeout");
            print_verdict();
        end
    endtask
    task automatic axi_wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] r);
        int n;
        bit a_ok, w_ok, b_ok;
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        a_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        for (n = 0; n < 50 && !b_ok; n++) begin
            @(posedge aclk);
            if (awready && !a_ok) begin
                a_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                b_ok = 1'b1;
                bready <= 1'b0;
            end
        end
        tmo(n, 50);
    endtask
    task automatic axi_rd(input logic [31:0] a, d, input logic [1:0] r);
        int n;
        bit a_ok, r_ok;
        rq.push_back({r, d});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        a_ok = 1'b0;
        r_ok = 1'b0;
        for (n = 0; n < 50 && !r_ok; n++) begin
            @(posedge aclk);
            if (arready && !a_ok) begin
                a_ok = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                r_ok = 1'b1;
                rready <= 1'b0;
            end
        end
        tmo(n, 50);
    endtask
    // ****************************************
    // result monitor
    // ****************************************
    always @(posedge aclk) begin
        if (fetch_valid === 1'b1) begin
            e = fq.size() ? fq.pop_front() : {34{1'bx}};
            `CHK("fetch", e, {fetch_paddr, fetch_uncached, sel})
        end
        if (rvalid === 1'b1 && rready === 1'b1) begin
            e = rq.size() ? rq.pop_front() : {34{1'bx}};
            `CHK("read", e, {rresp, rdata})
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            eb = bq.size() ? bq.pop_front() : 2'bxx;
            `CHK("bresp", eb, bresp)
        end
        if (due) begin
            `CHK("sram", wexp, read_word)
        end
        due <= fetch_valid === 1'b1 && sel === 1'b1;
        wexp <= 32'h5a00_0000 + fetch_paddr[5:2];
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        int n;
        logic [31:0] v, d;
        logic up;
        void'($urandom(49));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        supply_risen <= 1'b1;
        for (n = 0; n < 100 && core_reset_n !== 1'b1; n++) @(posedge aclk);
        tmo(n, 100);
        `CHK("ext_delay", 1'b1, n <= 5)
        `CHK("pll_off", 2'h0, pll_enable)
        `CHK("vector", 32'ha000_0000, boot_vector)
        for (int i = 0; i < 24; i++) begin
            v = $urandom();
            if (i == 0) v = 32'ha000_0000;
            else if (i % 3 == 1) v = {3'b101, v[28:0]};
            else if (i % 3 == 2) v = {6'h0, v[25:0]};
            up = (v[31:29] == 3'b101);
            d = up ? (v & 32'h1fff_ffff) : v;
            fq.push_back({d, up, d[31:26] == 6'h0});
            fetch_req <= 1'b1;
            fetch_vaddr <= v;
            @(posedge aclk);
        end
        fetch_req <= 1'b0;
        axi_rd(32'h08, 32'h0000_00ff, 2'h0);
        axi_rd(32'h04, 32'h0, 2'h0);
        axi_rd(32'h0c, 32'h9, 2'h0);
        for (int i = 0; i < 3; i++) begin
            d = $urandom();
            axi_wr(i * 4, d, 4'hf, 2'h0);
            axi_rd(i * 4, (i == 0) ? {30'h0, d[1:0]} : (i == 1) ? d : {24'h0, d[7:0]}, 2'h0);
        end
        `CHK("gates", d[7:0], module_clock_enable)
        axi_wr(32'h04, 32'h0, 4'hf, 2'h0);
        axi_wr(32'h04, 32'hffff_ffff, 4'h2, 2'h0);
        `CHK("divider", 32'h0000_ff00, clock_divider)
        axi_wr(32'h100, d, 4'hf, 2'h3);
        axi_rd(32'h100, 32'h0, 2'h3);
        axi_wr(32'h00, 32'h3, 4'hf, 2'h0);
        `CHK("pll_on", 2'h3, pll_enable)
        supply_risen <= 1'b0;
        strap <= 1'b0;
        for (n = 0; n < 20 && core_reset_n !== 1'b0; n++) @(posedge aclk);
        tmo(n, 20);
        `CHK("drop_delay", 1'b1, n <= 4)
        // held in reset: fetch and write vanish
        fetch_req <= 1'b1;
        axi_wr(32'h00, 32'h3, 4'hf, 2'h0);
        fetch_req <= 1'b0;
        supply_risen <= 1'b1;
        for (n = 0; n < 100 && core_reset_n !== 1'b1; n++) @(posedge aclk);
        tmo(n, 100);
        `CHK("xtal_delay", 1'b1, n >= SETTLE + 2)
        axi_rd(32'h00, 32'h0, 2'h0);
        axi_rd(32'h0c, 32'hb, 2'h0);
        repeat (2) @(posedge aclk);
        print_verdict();
    end
endmodule // boot_reset_clock_sequencer_test
